// File: rtl/boundary_scan_tap.sv
// test access port: state machine, instruction, bypass, boundary, id registers
// assumes tck is asynchronous and at least 4x slower than i_clk
`timescale 1ns/1ps
module boundary_scan_tap
    import tap_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire tap_pins_s             i_pins,
    input  wire logic [BSR_PINS-1:0]   i_ring,
    output logic                       o_tdo,
    output logic                       o_tdo_oe_n,
    output logic                       o_ram_hiz,
    output logic                       o_extest,
    output logic [BSR_WIDTH-1:0]       o_bsr_update
);

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    tap_pins_s  sync1_reg;
    tap_pins_s  sync2_reg;
    logic       tck_last_reg;
    logic       rise;
    logic       fall;
    logic       tms_s;
    logic       tdi_s;

    logic [BSR_PINS-1:0] ring_sync1_reg;
    logic [BSR_PINS-1:0] ring_sync2_reg;

    // reset to the idle pin levels so no false tck edge follows reset
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sync1_reg    <= '1;
            sync2_reg    <= '1;
            tck_last_reg <= 1'b1;
        end
        else
        begin
            sync1_reg    <= i_pins;
            sync2_reg    <= sync1_reg;
            tck_last_reg <= sync2_reg.tck;
        end
    end

    // ring pins run on the ram clock, not ours
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ring_sync1_reg <= '0;
            ring_sync2_reg <= '0;
        end
        else
        begin
            ring_sync1_reg <= i_ring;
            ring_sync2_reg <= ring_sync1_reg;
        end
    end

    assign rise  = sync2_reg.tck & ~tck_last_reg;
    assign fall  = ~sync2_reg.tck & tck_last_reg;
    // pull-up resolved after the flops, so no gate sits ahead of them
    assign tms_s = sync2_reg.tms | ~sync2_reg.tms_driven;
    assign tdi_s = sync2_reg.tdi | ~sync2_reg.tdi_driven;

    // ------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------
    tap_state_e state_reg;
    tap_state_e state_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TLR:     state_next = tms_s ? TLR    : RTI;
            RTI:     state_next = tms_s ? SEL_DR : RTI;
            SEL_DR:  state_next = tms_s ? SEL_IR : CAP_DR;
            CAP_DR:  state_next = tms_s ? EX1_DR : SH_DR;
            SH_DR:   state_next = tms_s ? EX1_DR : SH_DR;
            EX1_DR:  state_next = tms_s ? UPD_DR : PA_DR;
            PA_DR:   state_next = tms_s ? EX2_DR : PA_DR;
            EX2_DR:  state_next = tms_s ? UPD_DR : SH_DR;
            UPD_DR:  state_next = tms_s ? SEL_DR : RTI;
            SEL_IR:  state_next = tms_s ? TLR    : CAP_IR;
            CAP_IR:  state_next = tms_s ? EX1_IR : SH_IR;
            SH_IR:   state_next = tms_s ? EX1_IR : SH_IR;
            EX1_IR:  state_next = tms_s ? UPD_IR : PA_IR;
            PA_IR:   state_next = tms_s ? EX2_IR : PA_IR;
            EX2_IR:  state_next = tms_s ? UPD_IR : SH_IR;
            UPD_IR:  state_next = tms_s ? SEL_DR : RTI;
            default: state_next = TLR;
        endcase
    end

    // power-up reset lands in tlr; with no tck edges nothing moves
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            state_reg <= TLR;
        else if (rise)
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [IR_WIDTH-1:0] ir_shift_reg;
    logic [IR_WIDTH-1:0] instruction_reg;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            ir_shift_reg <= INS_IDREAD;
        else if (rise && state_reg == CAP_IR)
            ir_shift_reg <= {1'b0, IR_CAPTURE};
        else if (rise && state_reg == SH_IR)
            ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};
    end

    // active instruction changes only on update or reset
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            instruction_reg <= INS_IDREAD;
        else if (fall && state_reg == TLR)
            instruction_reg <= INS_IDREAD;
        else if (fall && state_reg == UPD_IR)
            instruction_reg <= ir_shift_reg;
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    function automatic logic sel_boundary(input logic [IR_WIDTH-1:0] ins);
        sel_boundary = (ins == INS_EXTEST) || (ins == INS_HIZ_SMPL) || (ins == INS_SAMPLE);
    endfunction : sel_boundary

    logic use_bsr;
    logic use_id;

    // 011, 101, 110 and 111 fall through to bypass
    assign use_bsr = sel_boundary(instruction_reg);
    assign use_id  = (instruction_reg == INS_IDREAD);

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic                 bypass_bit;
    logic [ID_WIDTH-1:0]  identification_reg;
    logic [BSR_WIDTH-1:0] bsr_reg;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            bypass_bit <= 1'b0;
        else if (rise && state_reg == CAP_DR)
            bypass_bit <= 1'b0;
        else if (rise && state_reg == SH_DR && !use_bsr && !use_id)
            bypass_bit <= tdi_s;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            identification_reg <= ID_CODE;
        else if (rise && state_reg == CAP_DR && use_id)
            identification_reg <= ID_CODE;
        else if (rise && state_reg == SH_DR && use_id)
            identification_reg <= {tdi_s, identification_reg[ID_WIDTH-1:1]};
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            bsr_reg <= '1;
        else if (rise && state_reg == CAP_DR && use_bsr)
            bsr_reg <= {{BSR_SPARE{1'b1}}, ring_sync2_reg};
        else if (rise && state_reg == SH_DR && use_bsr)
            bsr_reg <= {tdi_s, bsr_reg[BSR_WIDTH-1:1]};
    end

    // ------------------------------------------------------------
    // serial output, launched on falling tck
    // ------------------------------------------------------------
    logic tail;

    always_comb
    begin
        if (state_reg == SH_IR)
            tail = ir_shift_reg[0];
        else if (use_id)
            tail = identification_reg[0];
        else if (use_bsr)
            tail = bsr_reg[0];
        else
            tail = bypass_bit;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_tdo      <= 1'b1;
            o_tdo_oe_n <= 1'b1;
        end
        else if (fall)
        begin
            o_tdo      <= tail;
            o_tdo_oe_n <= !(state_reg == SH_IR || state_reg == SH_DR);
        end
    end

    // ------------------------------------------------------------
    // effects on the ram side
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_ram_hiz    <= 1'b0;
            o_extest     <= 1'b0;
            o_bsr_update <= '1;
        end
        else
        begin
            o_ram_hiz <= (instruction_reg == INS_HIZ_SMPL);
            o_extest  <= (instruction_reg == INS_EXTEST);
            if (fall && state_reg == UPD_DR && use_bsr)
                o_bsr_update <= bsr_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_oe_shift;
        @(posedge i_clk) disable iff (i_reset)
        !o_tdo_oe_n |-> ($past(state_reg) == SH_IR || $past(state_reg) == SH_DR
                         || state_reg == EX1_IR || state_reg == EX1_DR
                         || state_reg == SH_IR || state_reg == SH_DR);
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("tdo enabled outside shift");

    property p_tlr_ones;
        @(posedge i_clk) disable iff (i_reset)
        (rise && tms_s && state_reg == SEL_IR) |=> state_reg == TLR;
    endproperty
    a_tlr_ones: assert property (p_tlr_ones) else $error("no reset state entry");

    property p_tlr_ir;
        @(posedge i_clk) disable iff (i_reset)
        (fall && state_reg == TLR) |=> instruction_reg == INS_IDREAD;
    endproperty
    a_tlr_ir: assert property (p_tlr_ir) else $error("ir not idread after reset");

    property p_cap_ir;
        @(posedge i_clk) disable iff (i_reset)
        (rise && state_reg == CAP_IR) |=> ir_shift_reg[1:0] == IR_CAPTURE;
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

    property p_ir_hold;
        @(posedge i_clk) disable iff (i_reset)
        !(fall && (state_reg == UPD_IR || state_reg == TLR)) |=> $stable(instruction_reg);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");

    property p_id_cap;
        @(posedge i_clk) disable iff (i_reset)
        (rise && state_reg == CAP_DR && use_id) |=> identification_reg == ID_CODE;
    endproperty
    a_id_cap: assert property (p_id_cap) else $error("id capture wrong");

    property p_spare_one;
        @(posedge i_clk) disable iff (i_reset)
        (rise && state_reg == CAP_DR && use_bsr) |=> &bsr_reg[BSR_WIDTH-1:BSR_PINS];
    endproperty
    a_spare_one: assert property (p_spare_one) else $error("spare cell not one");

    property p_hiz;
        @(posedge i_clk) disable iff (i_reset)
        (instruction_reg == INS_HIZ_SMPL) [*2] |-> o_ram_hiz;
    endproperty
    a_hiz: assert property (p_hiz) else $error("ram outputs not floated");

    property p_idle;
        @(posedge i_clk) disable iff (i_reset)
        !rise |=> $stable(state_reg);
    endproperty
    a_idle: assert property (p_idle) else $error("state moved without tck");

endmodule : boundary_scan_tap

// File: rtl/tap_pkg.sv
// constants and carriers for the boundary-scan test access port
// assumes the tap is sampled by a 10 MHz system clock, tck far slower
package tap_pkg;

    localparam int          IR_WIDTH      = 3;
    localparam int          ID_WIDTH      = 32;
    localparam int          BSR_PINS      = 8;
    localparam int          BSR_SPARE     = 2;
    localparam int          BSR_WIDTH     = BSR_PINS + BSR_SPARE;
    localparam int          RESET_ONES    = 5;

    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_IDREAD    = 3'h1;
    localparam logic [2:0]  INS_HIZ_SMPL  = 3'h2;
    localparam logic [2:0]  INS_SAMPLE    = 3'h4;
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;

    // identification fields; values arbitrary
    localparam logic [3:0]  ID_REVISION   = 4'h1;
    localparam logic [15:0] ID_IO_CONFIG  = 16'h0000;
    localparam logic [10:0] ID_VENDOR     = 11'h055;
    localparam logic        ID_PRESENCE   = 1'b1;
    localparam logic [31:0] ID_CODE       = {ID_REVISION, ID_IO_CONFIG, ID_VENDOR, ID_PRESENCE};

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic tms_driven;
        logic tdi_driven;
    } tap_pins_s;

endpackage : tap_pkg

// File: test/scan_master.sv
// model of the external scan controller driving the tap pins
// assumes pins change on falling i_clk and tck idles high between scans
`timescale 1ns/1ps
module scan_master
    import tap_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe_n,
    output tap_pins_s o_pins
);
    logic tms_float;
    logic tdi_float;

    initial
    begin
        o_pins    = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        tms_float = 1'b0;
        tdi_float = 1'b0;
    end

    // one 8-cycle tck period: fall, tdo taken late in low phase, rise
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
        @(negedge i_clk);
        o_pins.tck        <= 1'b0;
        // released pins show garbage; only the pull-up makes them read one
        o_pins.tms        <= tms_float ? ~o_pins.tms : tms;
        o_pins.tms_driven <= ~tms_float;
        o_pins.tdi        <= tdi_float ? ~o_pins.tdi : tdi;
        o_pins.tdi_driven <= ~tdi_float;
        repeat (4) @(negedge i_clk);
        oe_n = i_tdo_oe_n;
        tdo  = i_tdo_oe_n ? 1'bz : i_tdo;
        o_pins.tck <= 1'b1;
        repeat (3) @(negedge i_clk);
    endtask : step
endmodule : scan_master

// File: test/tb.sv
// self-checking bench for the boundary-scan tap
// assumes scan_master drives the pins at the 800 ns tck period
`timescale 1ns/1ps
module tb
    import tap_pkg::*;
;
    logic                 i_clk = 1'b0;
    logic                 i_reset = 1'b1;
    tap_pins_s            pins;
    logic [BSR_PINS-1:0]  ring = '0;
    logic                 tdo;
    logic                 tdo_oe_n;
    logic                 ram_hiz;
    logic                 extest;
    logic [BSR_WIDTH-1:0] bsr_update;
    int                   fail_count = 0;
    int                   n_tests = 0;

    always #50 i_clk = ~i_clk;

    boundary_scan_tap boundary_scan_tap_i (.i_clk(i_clk), .i_reset(i_reset), .i_pins(pins),
        .i_ring(ring), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .o_ram_hiz(ram_hiz),
        .o_extest(extest), .o_bsr_update(bsr_update));
    scan_master scan_master_i (.i_clk(i_clk), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n),
        .o_pins(pins));

    // ----------------------------------------
    // checking and scan tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // from idle through one ir or dr scan and back to idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dq);
        logic b;
        logic oe_n;
        logic ext_before;
        dq         = '0;
        ext_before = extest;
        scan_master_i.step(1'b1, 1'b1, b, oe_n);
        if (ir)
            scan_master_i.step(1'b1, 1'b1, b, oe_n);
        scan_master_i.step(1'b0, 1'b1, b, oe_n);
        scan_master_i.step(1'b0, 1'b1, b, oe_n);
        for (int i = 0; i < n; i++)
        begin
            scan_master_i.step(i == n - 1, din[i], dq[i], oe_n);
            chk(oe_n, 1'b0, "enable in shift");
        end
        scan_master_i.step(1'b1, 1'b1, b, oe_n);
        chk(oe_n, 1'b1, "enable in exit");
        chk(extest, ext_before, "instruction before update");
        scan_master_i.step(1'b0, 1'b1, b, oe_n);
    endtask : scan

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] q;
        logic [9:0]  din;
        logic        b;
        logic        oe;
        repeat (2) @(negedge i_clk);
        i_reset = 1'b0;
        chk({tdo_oe_n, ram_hiz, extest, bsr_update}, 13'h13ff, "after reset");
        scan_master_i.step(1'b0, 1'b1, b, oe);
        scan(1'b0, 32'h0, ID_WIDTH, q);
        chk(q, ID_CODE, "identification code");
        chk(q[0], 1'b1, "first bit out");
        chk({q[31:28], q[11:0]}, {ID_REVISION, ID_VENDOR, 1'b1}, "id fields");
        for (int c = 0; c < 8; c++)
        begin
            ring = 8'h5a ^ 8'(c);
            din  = 10'h2c3 ^ 10'(c);
            scan(1'b1, 32'(c), IR_WIDTH, q);
            chk(q[1:0], IR_CAPTURE, "ir capture");
            chk({ram_hiz, extest}, {c == 2, c == 0}, "decode");
            scan(1'b0, 32'(din), BSR_WIDTH, q);
            if (c == 0 || c == 2 || c == 4)
            begin
                chk(q[9:0], {2'b11, 8'h5a ^ 8'(c)}, "boundary capture");
                chk(bsr_update, din, "boundary update");
            end
            else if (c == 1)
                chk(q[9:0], ID_CODE[9:0], "id path");
            else
                chk(q[9:0], {din[8:0], 1'b0}, "bypass path");
        end
        scan_master_i.tdi_float = 1'b1;
        scan(1'b0, 32'h0, 4, q);
        chk(q[3:0], 4'he, "undriven data input");
        scan_master_i.tdi_float = 1'b0;
        scan(1'b1, 32'(INS_HIZ_SMPL), IR_WIDTH, q);
        chk(ram_hiz, 1'b1, "high-z sample active");
        // park in shift-dr, the longest way back to reset state
        scan_master_i.step(1'b1, 1'b1, b, oe);
        scan_master_i.step(1'b0, 1'b1, b, oe);
        scan_master_i.step(1'b0, 1'b1, b, oe);
        // five rises reach reset state, the sixth fall lands the instruction
        scan_master_i.tms_float = 1'b1;
        repeat (6) scan_master_i.step(1'b0, 1'b1, b, oe);
        chk({ram_hiz, tdo_oe_n}, 2'b01, "undriven mode select reset");
        scan_master_i.tms_float = 1'b0;
        scan_master_i.step(1'b0, 1'b1, b, oe);
        scan(1'b0, 32'h0, ID_WIDTH, q);
        chk(q, ID_CODE, "instruction after reset state");
        stop_test();
    end

    initial
    begin
        #2_000_000;
        fail_count++;
        stop_test();
    end
endmodule : tb
